/* File: include/ssm_defs.svh */
// ssm_defs.svh: timing constants and field positions for the satellite sync mode control block
// assumes a 10 MHz core clock (100 ns period); included by bare name
`ifndef SSM_DEFS_SVH
`define SSM_DEFS_SVH

`define SSM_CLK_PERIOD_NS     100
// sync pulse high time options, ns
`define SSM_SEL_A_NS          30000
`define SSM_SEL_B_NS          60000
`define SSM_SEL_C_NS          120000
`define SSM_SEL_D_NS          250000
// trigger to pulse delay, low-limit start, low-limit duration, blanking, ns
`define SSM_TRIG_DLY_NS       2000
`define SSM_LOWLIM_START_NS   1500
`define SSM_LOWLIM_LEN_NS     200
`define SSM_BLANK_NS          100000
// cycle counts: least times round up, at least one cycle
`define SSM_CYC_UP(ns) (((ns) + `SSM_CLK_PERIOD_NS - 1) / `SSM_CLK_PERIOD_NS)
`define SSM_CNT_W             12
// field positions of the sync time selection in the main configuration word
`define SSM_SEL_HI            9
`define SSM_SEL_LO            8
`define SSM_CHANNELS          4
`define SSM_MSG_W             16

`endif

/* File: include/ssm_pkg.sv */
// ssm_pkg.sv: types for the satellite sync mode control block
// assumes ssm_defs.svh for all numeric constants
package ssm_pkg;
  typedef enum logic [1:0] {
    SSM_MODE_RECEIVE,
    SSM_MODE_SYNC,
    SSM_MODE_HV,
    SSM_MODE_OFF
  } ssm_mode_e;

  typedef enum logic [2:0] {
    SSM_ST_IDLE,
    SSM_ST_DELAY,
    SSM_ST_LOWLIM,
    SSM_ST_PULSE,
    SSM_ST_BLANK
  } ssm_state_e;
endpackage : ssm_pkg

/* File: hdl/ssm_sync2.sv */
// ssm_sync2.sv: two-flop synchroniser for one level from outside the clock domain
// assumes a single clock, synchronous active-high reset, clock enable
`timescale 1ns/1ps
module ssm_sync2 (
  input  wire logic clk,
  input  wire logic srst,
  input  wire logic ce,
  input  wire logic d,
  output logic      q
);
  logic meta_r;

  // the first stage feeds only the second stage
  always_ff @(posedge clk) begin
    if (srst) begin
      meta_r <= 1'b0;
      q      <= 1'b0;
    end else if (ce) begin
      meta_r <= d;
      q      <= meta_r;
    end
  end
endmodule : ssm_sync2

/* File: hdl/ssm_buf2.sv */
// ssm_buf2.sv: two-entry valid/ready buffer for decoded satellite words
// assumes single clock; the drain side may stall at any time
`timescale 1ns/1ps
`include "ssm_defs.svh"
module ssm_buf2 #(
  parameter int W = `SSM_MSG_W
) (
  input  wire logic         clk,
  input  wire logic         srst,
  input  wire logic         ce,
  input  wire logic         in_valid,
  output logic              in_ready,
  input  wire logic [W-1:0] in_data,
  output logic              out_valid,
  input  wire logic         out_ready,
  output logic [W-1:0]      out_data
);
  logic [W-1:0] mem_r [2];
  logic         wp_r;
  logic         rp_r;
  logic [1:0]   cnt_r;
  logic         push;
  logic         pop;

  assign in_ready  = (cnt_r != 2'h2);
  assign out_valid = (cnt_r != 2'h0);
  assign out_data  = mem_r[rp_r];
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  // storage is not reset; only occupancy matters
  always_ff @(posedge clk) begin
    if (ce && push) begin
      mem_r[wp_r] <= in_data;
    end
  end

  // pointers and count
  always_ff @(posedge clk) begin
    if (srst) begin
      wp_r  <= 1'b0;
      rp_r  <= 1'b0;
      cnt_r <= 2'h0;
    end else if (ce) begin
      if (push) begin
        wp_r <= ~wp_r;
      end
      if (pop) begin
        rp_r <= ~rp_r;
      end
      cnt_r <= cnt_r + {1'b0, push} - {1'b0, pop};
    end
  end
endmodule : ssm_buf2

/* File: hdl/ssm_ctrl.sv */
// ssm_ctrl.sv: sync pulse sequencing, receiver blanking and message path for four channels
// assumes ssm_defs.svh, ssm_pkg, ssm_sync2, ssm_buf2; sync trigger is an async pin
//
// Behaviour
// (RULE1) after trigger rise plus fixed delay, pulse all channels in sync or HV mode
// (RULE2) pulse high time follows the two-bit sync time selection field
// (RULE3) selection resets to the shortest option until software writes it
// (RULE4) messages keep flowing in sync or HV mode without any trigger
// (RULE5) host picks options a/b in sync mode, c/d in HV mode
// (RULE6) host discards HV-mode messages while short-to-battery flag is set
// (RULE7) reduced current limit starts fixed time after trigger, lasts 200 ns
// (RULE8) trigger changes ignored and no new pulse while blanking runs
// (RULE9) decoders disabled through pulse and whole blanking interval
// (RULE10) blanking interval is timed from the trigger rising edge
// (RULE11) one command enables both sync and HV mode, using the sync supply
// (RULE12) up to two satellites share a channel by time slots after the pulse
// (RULE13) receive mode is asynchronous, continuous, with no sync pulses
// (RULE14) decoded words go to the sensor host port; config port resets circuits
// (RULE15) sensed channel current is demodulated into a bit stream for decoding
// (RULE16) all channel outputs stay off while logic supply is absent
// (RULE17) sync mode outputs sit at receive level except during each pulse
// (RULE18) in HV mode host gates the receiver around each sent frame
// (RULE19) trigger is synchronised and its rising edge detected before timing
// (RULE20) delay, pulse and blanking timed by counters with named constants
`timescale 1ns/1ps
`include "ssm_defs.svh"
module ssm_ctrl (
  input  wire logic                         clk,
  input  wire logic                         srst,
  input  wire logic                         ce,
  input  wire logic                         sync_trigger_in,
  input  wire logic                         logic_supply_ok,
  input  wire logic                         config_host_reset,
  input  wire logic                         sync_mode_cmd,
  input  wire logic                         sync_mode_cmd_stb,
  input  wire logic                         hv_select,
  input  wire logic [1:0]                   main_config_reg_sel,
  input  wire logic                         main_config_reg_stb,
  input  wire logic                         receiver_enable,
  input  wire logic [`SSM_CHANNELS-1:0]     sensor_current_high,
  input  wire logic [`SSM_CHANNELS-1:0]     decoded_valid,
  input  wire logic [`SSM_MSG_W-1:0]        decoded_data,
  output logic                              decoded_ready,
  output logic                              sensor_host_port_valid,
  input  wire logic                         sensor_host_port_ready,
  output logic [`SSM_MSG_W-1:0]             sensor_host_port_data,
  output logic [`SSM_CHANNELS-1:0]          sensor_channel_out,
  output logic [`SSM_CHANNELS-1:0]          channel_hv_out,
  output logic [`SSM_CHANNELS-1:0]          low_limit_out,
  output logic [`SSM_CHANNELS-1:0]          decoder_enable_out,
  output logic [`SSM_CHANNELS-1:0]          demod_bit_out,
  output logic                              sync_supply_sel_out,
  output logic                              blanking_out
);
  // cycle counts round up so no window comes out shorter than its nominal time
  localparam int CW = `SSM_CNT_W;
  localparam logic [CW-1:0] DLY_CYC  = CW'(`SSM_CYC_UP(`SSM_TRIG_DLY_NS));
  localparam logic [CW-1:0] LLS_CYC  = CW'(`SSM_CYC_UP(`SSM_LOWLIM_START_NS));
  localparam logic [CW-1:0] LLL_CYC  = CW'(`SSM_CYC_UP(`SSM_LOWLIM_LEN_NS));
  localparam logic [CW-1:0] BLK_CYC  = CW'(`SSM_CYC_UP(`SSM_BLANK_NS));

  ////////////////////////////////////////////////////////////////////////////////
  // pulse length decode, used for the running pulse and its end check
  // the four options lie far apart, so a wrong decode shows as a gross length error
  function automatic logic [CW-1:0] pulse_cycles(input logic [1:0] sel);
    case (sel)
      2'h0:    pulse_cycles = CW'(`SSM_CYC_UP(`SSM_SEL_A_NS));
      2'h1:    pulse_cycles = CW'(`SSM_CYC_UP(`SSM_SEL_B_NS));
      2'h2:    pulse_cycles = CW'(`SSM_CYC_UP(`SSM_SEL_C_NS));
      default: pulse_cycles = CW'(`SSM_CYC_UP(`SSM_SEL_D_NS));
    endcase
  endfunction : pulse_cycles

  ////////////////////////////////////////////////////////////////////////////////
  logic                   trig_s;
  logic                   trig_d_r;
  logic                   trig_rise;
  logic                   trig_take;
  logic                   supply_s;
  logic [`SSM_CHANNELS-1:0] cur_s;
  logic                   sync_en_r;
  logic                   hv_r;
  logic [1:0]             sel_r;
  logic [1:0]             run_sel_r;
  ssm_pkg::ssm_state_e    st_r;
  logic [CW-1:0]          seq_cnt_r;
  logic [CW-1:0]          blk_cnt_r;
  logic                   blk_r;
  logic                   pulse_act;
  logic                   low_act;
  logic                   dec_on;
  logic                   buf_in_ready;

  // external levels pass two flops before use
  // the trigger's two cycles of latency add to the fixed trigger delay, which is counted from the detected edge
  ssm_sync2 u_trig (
    .clk  (clk),
    .srst (srst),
    .ce   (ce),
    .d    (sync_trigger_in),
    .q    (trig_s)
  ); // RULE19
  ssm_sync2 u_supply (
    .clk  (clk),
    .srst (srst),
    .ce   (ce),
    .d    (logic_supply_ok),
    .q    (supply_s)
  );

  // current comparators sit in the analog domain, so each is synchronised
  generate
    for (genvar g = 0; g < `SSM_CHANNELS; g++) begin : g_cur
      ssm_sync2 u_cur (
        .clk  (clk),
        .srst (srst),
        .ce   (ce),
        .d    (sensor_current_high[g]),
        .q    (cur_s[g])
      );
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////////
  // edge detect on the synchronised trigger only
  // reset value matches the idle low pin, so no false edge follows reset
  always_ff @(posedge clk) begin
    if (srst) begin
      trig_d_r <= 1'b0;
    end else if (ce) begin
      trig_d_r <= trig_s;
    end
  end
  assign trig_rise = trig_s && !trig_d_r; // RULE19
  // a trigger counts only in sync or HV mode, outside blanking and with the
  // sequencer idle; one term starts both timers so they cannot disagree
  assign trig_take = trig_rise && sync_en_r && !blk_r &&
                     (st_r == ssm_pkg::SSM_ST_IDLE); // RULE8 RULE13

  ////////////////////////////////////////////////////////////////////////////////
  // mode and selection state; a config-port reset returns to receive mode
  // the selection is only a request; the sequencer copies it when a trigger is taken
  always_ff @(posedge clk) begin
    if (srst || config_host_reset) begin // RULE14
      sync_en_r <= 1'b0;
      hv_r      <= 1'b0;
      sel_r     <= 2'h0; // RULE3
    end else if (ce) begin
      if (sync_mode_cmd_stb) begin
        sync_en_r <= sync_mode_cmd; // RULE11
        hv_r      <= hv_select;
      end
      if (main_config_reg_stb) begin
        sel_r <= main_config_reg_sel; // RULE2
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // blanking timer, started by the trigger edge itself
  // blanking may outlast a short pulse; decoders wait for whichever ends later
  always_ff @(posedge clk) begin
    if (srst || config_host_reset) begin
      blk_r     <= 1'b0;
      blk_cnt_r <= '0;
    end else if (ce) begin
      if (trig_take) begin // RULE10 RULE8
        blk_r     <= 1'b1;
        blk_cnt_r <= BLK_CYC - CW'(1);
      end else if (blk_r) begin
        if (blk_cnt_r == '0) begin
          blk_r <= 1'b0;
        end else begin
          blk_cnt_r <= blk_cnt_r - CW'(1);
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // pulse sequence: delay, reduced-limit slot, pulse high
  // a pulse that outlasts blanking still finishes; edges during it are ignored
  // the selection is copied at the trigger so a later write cannot stretch a pulse
  always_ff @(posedge clk) begin
    if (srst || config_host_reset) begin
      st_r      <= ssm_pkg::SSM_ST_IDLE;
      seq_cnt_r <= '0;
      run_sel_r <= 2'h0;
    end else if (ce) begin
      case (st_r)
        ssm_pkg::SSM_ST_IDLE: begin
          if (trig_take) begin // RULE1 RULE8 RULE13
            st_r      <= ssm_pkg::SSM_ST_DELAY;
            seq_cnt_r <= CW'(1);
            run_sel_r <= sel_r;
          end
        end
        ssm_pkg::SSM_ST_DELAY: begin
          seq_cnt_r <= seq_cnt_r + CW'(1);
          if (seq_cnt_r == LLS_CYC) begin // RULE7
            st_r <= ssm_pkg::SSM_ST_LOWLIM;
          end
        end
        ssm_pkg::SSM_ST_LOWLIM: begin
          seq_cnt_r <= seq_cnt_r + CW'(1);
          if (seq_cnt_r == LLS_CYC + LLL_CYC) begin // RULE7
            st_r <= ssm_pkg::SSM_ST_PULSE;
          end
        end
        ssm_pkg::SSM_ST_PULSE: begin
          seq_cnt_r <= seq_cnt_r + CW'(1);
          if (seq_cnt_r == DLY_CYC + pulse_cycles(run_sel_r)) begin // RULE2 RULE20
            st_r <= ssm_pkg::SSM_ST_BLANK;
          end
        end
        ssm_pkg::SSM_ST_BLANK: begin
          if (!blk_r) begin
            st_r <= ssm_pkg::SSM_ST_IDLE;
          end
        end
        default: st_r <= ssm_pkg::SSM_ST_IDLE;
      endcase
    end
  end

  // pulse proper begins once the trigger delay has run out
  assign pulse_act = (st_r == ssm_pkg::SSM_ST_PULSE) && (seq_cnt_r > DLY_CYC); // RULE1
  // the reduced limit holds for its own window only; the rest of the delay runs
  // at the normal limit so the pins can recharge before the pulse
  assign low_act   = (st_r == ssm_pkg::SSM_ST_LOWLIM); // RULE7
  // decoders run while receiver_enable is high, unless a pulse or blanking is in progress
  assign dec_on    = receiver_enable && !blk_r &&
                     (st_r == ssm_pkg::SSM_ST_IDLE ||
                      st_r == ssm_pkg::SSM_ST_BLANK); // RULE9 RULE4 RULE18

  ////////////////////////////////////////////////////////////////////////////////
  // registered channel outputs; lost supply forces every channel output and the supply select off, not blanking_out
  // outputs are registered so the pins never glitch on a state change
  always_ff @(posedge clk) begin
    if (srst) begin
      sensor_channel_out  <= '0;
      channel_hv_out      <= '0;
      low_limit_out       <= '0;
      decoder_enable_out  <= '0;
      demod_bit_out       <= '0;
      sync_supply_sel_out <= 1'b0;
      blanking_out        <= 1'b0;
    end else if (ce) begin
      sensor_channel_out  <= {`SSM_CHANNELS{supply_s}}; // RULE16
      channel_hv_out      <= {`SSM_CHANNELS{supply_s && pulse_act &&
                              (hv_r || sync_en_r)}}; // RULE17 RULE12
      low_limit_out       <= {`SSM_CHANNELS{supply_s && low_act}}; // RULE7
      decoder_enable_out  <= {`SSM_CHANNELS{supply_s && dec_on}}; // RULE9
      demod_bit_out       <= cur_s & {`SSM_CHANNELS{supply_s && dec_on}}; // RULE15
      sync_supply_sel_out <= supply_s && sync_en_r; // RULE11
      blanking_out        <= blk_r;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // decoded word path toward the sensor host port; stall holds the decoder
  logic [`SSM_MSG_W-1:0] bo_data;
  logic                  bo_valid;
  logic                  bo_take;
  logic                  dec_push;
  logic                  bo_pop;
  logic                  buf_fills;

  // the source sees ready one cycle late, so ready drops whenever the word that
  // may arrive now could take the last free entry; no word is lost or taken
  // twice, at the price of an idle cycle when the buffer is nearly full
  assign dec_push  = (|decoded_valid) && decoded_ready; // RULE14
  assign bo_pop    = bo_valid && bo_take;
  assign buf_fills = !bo_pop && (!buf_in_ready || (bo_valid && dec_push));

  ssm_buf2 #(
    .W (`SSM_MSG_W)
  ) u_buf (
    .clk       (clk),
    .srst      (srst),
    .ce        (ce),
    .in_valid  (dec_push),
    .in_ready  (buf_in_ready),
    .in_data   (decoded_data),
    .out_valid (bo_valid),
    .out_ready (bo_take),
    .out_data  (bo_data)
  ); // RULE14

  // output stage register so port outputs come from flops
  // a word waits here while the host stalls; the buffer absorbs two more
  assign bo_take = !sensor_host_port_valid || sensor_host_port_ready;
  always_ff @(posedge clk) begin
    if (srst) begin
      sensor_host_port_valid <= 1'b0;
      sensor_host_port_data  <= '0;
      decoded_ready          <= 1'b0;
    end else if (ce) begin
      decoded_ready <= !buf_fills;
      if (bo_take) begin
        sensor_host_port_valid <= bo_valid;
        sensor_host_port_data  <= bo_data;
      end
    end
  end
endmodule : ssm_ctrl

/* File: tb/ssm_ctrl_checker.sv */
// ssm_ctrl_checker.sv: port-level assertions for the sync mode control block
// assumes one clock, srst synchronous active high; bound to ssm_ctrl below
`timescale 1ns/1ps
`include "ssm_defs.svh"
module ssm_ctrl_checker (
  input wire logic                     clk,
  input wire logic                     srst,
  input wire logic                     logic_supply_ok,
  input wire logic                     config_host_reset,
  input wire logic                     sync_mode_cmd,
  input wire logic                     sync_mode_cmd_stb,
  input wire logic [`SSM_CHANNELS-1:0] sensor_channel_out,
  input wire logic [`SSM_CHANNELS-1:0] channel_hv_out,
  input wire logic [`SSM_CHANNELS-1:0] low_limit_out,
  input wire logic [`SSM_CHANNELS-1:0] decoder_enable_out,
  input wire logic [`SSM_CHANNELS-1:0] demod_bit_out,
  input wire logic                     sync_supply_sel_out,
  input wire logic                     blanking_out
);
  logic [11:0] blank_len_r;
  ////////////////////////////////////////////////////////////////////////////////
  // age of the blanking window; pulse events are placed against it
  always_ff @(posedge clk) begin
    if (srst) blank_len_r <= 12'h000;
    else if (blanking_out) blank_len_r <= blank_len_r + 12'h001;
    else blank_len_r <= 12'h000;
  end
  ////////////////////////////////////////////////////////////////////////////////
  // one domain, so clock and disable are given once
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);
  sequence s_low_hold; low_limit_out[0] [*2] ##1 !low_limit_out[0]; endsequence
  sequence s_dec_off; (decoder_enable_out == 4'h0) [*2]; endsequence
  chk_low_limit_len: assert property ($rose(low_limit_out[0]) |-> s_low_hold)
    else $error("reduced limit window too short");
  chk_low_limit_place: assert property ($rose(low_limit_out[0]) |->
    blanking_out && blank_len_r >= 12'h008 && blank_len_r <= 12'h012)
    else $error("reduced limit window out of place");
  chk_low_then_pulse: assert property ($rose(low_limit_out[0]) |-> ##[1:8] channel_hv_out[0])
    else $error("no pulse after reduced limit window");
  chk_pulse_start: assert property ($rose(channel_hv_out[0]) |->
    channel_hv_out == 4'hF && blank_len_r >= 12'h00E && blank_len_r <= 12'h018)
    else $error("pulse start misplaced or not on all channels");
  chk_blank_length: assert property ($fell(blanking_out) |-> blank_len_r >= 12'h3E8)
    else $error("blanking window ended early");
  chk_decoder_off: assert property (($past(blanking_out) && blanking_out) ||
    ($past(channel_hv_out[0]) && channel_hv_out[0]) |-> decoder_enable_out == 4'h0)
    else $error("decoder enabled during blanking or pulse");
  chk_demod_masked: assert property (s_dec_off |-> demod_bit_out == 4'h0)
    else $error("demodulated bits not masked");
  chk_recv_no_pulse: assert property (!sync_supply_sel_out && !$past(sync_supply_sel_out) |->
    channel_hv_out == 4'h0 && low_limit_out == 4'h0)
    else $error("pulse activity in receive mode");
  chk_mode_on: assert property (sync_mode_cmd_stb && sync_mode_cmd && !config_host_reset |->
    ##[1:2] sync_supply_sel_out)
    else $error("mode command did not select sync supply");
  chk_mode_off: assert property (sync_mode_cmd_stb && !sync_mode_cmd |->
    ##[1:2] !sync_supply_sel_out)
    else $error("mode command did not release sync supply");
  chk_supply_loss: assert property ((!logic_supply_ok) [*4] |-> sensor_channel_out == 4'h0)
    else $error("channel outputs on without logic supply");
endmodule : ssm_ctrl_checker

bind ssm_ctrl ssm_ctrl_checker i_ssm_ctrl_checker (.clk, .srst, .logic_supply_ok,
  .config_host_reset, .sync_mode_cmd, .sync_mode_cmd_stb, .sensor_channel_out, .channel_hv_out,
  .low_limit_out, .decoder_enable_out, .demod_bit_out, .sync_supply_sel_out, .blanking_out);

/* File: tb/ssm_sat_model.sv */
// ssm_sat_model.sv: satellite side, offers decoded words and the channel current level
// assumes the bench queues words by word_stb; one word per valid/ready handshake
`timescale 1ns/1ps
module ssm_sat_model (
  input wire logic   clk,
  input wire logic   srst,
  input wire logic [15:0] word_in,
  input wire logic   word_stb,
  input wire logic   decoded_ready,
  output logic [3:0] decoded_valid,
  output logic [15:0] decoded_data,
  output logic [3:0] sensor_current_high
);
  logic [15:0] q[$];
  logic [1:0]  ch_r;
  ////////////////////////////////////////////////////////////////////////////////
  // words offered in order, held until taken; released data is inverted so it shows nothing
  always_ff @(posedge clk) begin
    if (srst) begin
      decoded_valid <= 4'h0;
      decoded_data <= 16'h0000;
      sensor_current_high <= 4'h0;
      ch_r <= 2'h0;
    end else begin
      if (word_stb) q.push_back(word_in);
      if (decoded_valid != 4'h0 && decoded_ready) begin
        decoded_valid <= 4'h0;
        decoded_data <= ~decoded_data;
        sensor_current_high <= decoded_data[3:0];
      end else if (decoded_valid == 4'h0 && q.size() > 0) begin
        decoded_valid <= 4'h1 << ch_r;
        decoded_data <= q.pop_front();
        ch_r <= ch_r + 2'h1;
      end
    end
  end
endmodule : ssm_sat_model

/* File: tb/ssm_ctrl_bench.sv */
// ssm_ctrl_bench.sv: self-checking bench for the sync mode control block
// assumes ssm_ctrl, ssm_sat_model and the bound checker; 10 MHz clock
`timescale 1ns/1ps
`include "ssm_defs.svh"
module ssm_ctrl_bench;
  localparam int PLEN[4] = '{`SSM_CYC_UP(`SSM_SEL_A_NS), `SSM_CYC_UP(`SSM_SEL_B_NS),
                             `SSM_CYC_UP(`SSM_SEL_C_NS), `SSM_CYC_UP(`SSM_SEL_D_NS)};
  logic clk = 1'b0, srst = 1'b1, ce = 1'b1, sync_trigger_in = 1'b0, logic_supply_ok = 1'b1;
  logic config_host_reset = 1'b0, sync_mode_cmd = 1'b0, sync_mode_cmd_stb = 1'b0;
  logic hv_select = 1'b0, main_config_reg_stb = 1'b0, receiver_enable = 1'b1;
  logic sensor_host_port_ready = 1'b0, word_stb = 1'b0, stall = 1'b0;
  logic [1:0] main_config_reg_sel = 2'h0;
  logic [15:0] word_in = 16'h0000, last_w = 16'h0000, sensor_host_port_data, decoded_data;
  logic [3:0] sensor_current_high, decoded_valid, sensor_channel_out, channel_hv_out;
  logic [3:0] low_limit_out, decoder_enable_out, demod_bit_out;
  logic decoded_ready, sensor_host_port_valid, sync_supply_sel_out, blanking_out;
  logic [31:0] seed = 32'h000123D1, hv_len = 32'h0;
  logic [15:0] exp_w[$];
  logic [31:0] exp_len[$];
  int mismatches = 0, compares = 0;
  ////////////////////////////////////////////////////////////////////////////////
  // design and satellite side
  ssm_ctrl i_ssm_ctrl (.clk, .srst, .ce, .sync_trigger_in, .logic_supply_ok, .config_host_reset,
    .sync_mode_cmd, .sync_mode_cmd_stb, .hv_select, .main_config_reg_sel, .main_config_reg_stb,
    .receiver_enable, .sensor_current_high, .decoded_valid, .decoded_data, .decoded_ready,
    .sensor_host_port_valid, .sensor_host_port_ready, .sensor_host_port_data,
    .sensor_channel_out, .channel_hv_out, .low_limit_out, .decoder_enable_out,
    .demod_bit_out, .sync_supply_sel_out, .blanking_out);
  ssm_sat_model i_ssm_sat_model (.clk, .srst, .word_in, .word_stb, .decoded_ready,
    .decoded_valid, .decoded_data, .sensor_current_high);
  always #50 clk = ~clk;
  ////////////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] xs(input logic [31:0] x);
    x = x ^ (x << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction : xs
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      mismatches++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check
  task automatic close_out();
    $display("compares=%0d mismatches=%0d", compares, mismatches);
    if (mismatches == 0 && compares > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : close_out
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask : tick
  task automatic send(input int n);
    for (int i = 0; i < n; i++) begin
      exp_w.push_back(seed[15:0]);
      last_w = seed[15:0];
      word_in <= seed[15:0];
      word_stb <= 1'b1;
      @(posedge clk);
    end
    word_stb <= 1'b0;
  endtask : send
  task automatic mode(input logic on, input logic hv);
    sync_mode_cmd <= on;
    hv_select <= hv;
    sync_mode_cmd_stb <= 1'b1;
    tick(1);
    sync_mode_cmd_stb <= 1'b0;
    tick(4);
  endtask : mode
  // second rise lands inside blanking and must be ignored
  task automatic trig(input logic [31:0] len);
    if (len != 0) exp_len.push_back(len);
    sync_trigger_in <= 1'b1;
    tick(4);
    sync_trigger_in <= 1'b0;
    tick(30);
    #1;
    if (len != 0) check(blanking_out, 1'b1);
    if (len != 0) check(decoder_enable_out, 4'h0);
    @(posedge clk);
    sync_trigger_in <= 1'b1;
    tick(4);
    sync_trigger_in <= 1'b0;
    for (int i = 0; i < 4000 && (blanking_out || channel_hv_out[0]); i++) @(posedge clk);
    receiver_enable <= 1'b1;
    tick(10);
    #1;
    check(decoder_enable_out, 4'hF);
    @(posedge clk);
  endtask : trig
  ////////////////////////////////////////////////////////////////////////////////
  // host side: random readiness, with a stall phase to fill the buffer
  always @(posedge clk) begin
    seed <= xs(seed);
    sensor_host_port_ready <= !stall && seed[3];
  end
  // result watcher: takes the oldest note whenever a word is taken or a pulse ends
  // the host keeps every word: no short-to-battery flag is raised in these runs
  always @(posedge clk) begin
    if (sensor_host_port_valid && sensor_host_port_ready) begin
      if (exp_w.size() == 0) check(32'hFFFFFFFF, 32'h0);
      else check(sensor_host_port_data, exp_w.pop_front());
    end
    if (channel_hv_out[0]) hv_len <= hv_len + 32'h1;
    else if (hv_len != 32'h0) begin
      if (exp_len.size() == 0) check(hv_len, 32'h0);
      else check(hv_len, exp_len.pop_front());
      hv_len <= 32'h0;
    end
  end
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    tick(5);
    srst <= 1'b0;
    tick(8);
    #1;
    check(sensor_channel_out, 4'hF);
    @(posedge clk);
    logic_supply_ok <= 1'b0;
    tick(8);
    #1;
    check(sensor_channel_out, 4'h0);
    @(posedge clk);
    logic_supply_ok <= 1'b1;
    send(3);
    trig(32'h0);
    mode(1'b1, 1'b0);
    trig(PLEN[0]);
    send(3);
    for (int s = 0; s < 4; s++) begin
      main_config_reg_sel <= s[1:0];
      main_config_reg_stb <= 1'b1;
      tick(1);
      main_config_reg_stb <= 1'b0;
      mode(1'b1, s >= 2);
      receiver_enable <= (s < 2);
      trig(PLEN[s]);
    end
    stall <= 1'b1;
    send(5);
    tick(20);
    #1;
    check(decoded_ready, 1'b0);
    check(sensor_host_port_valid, 1'b1);
    stall <= 1'b0;
    tick(200);
    #1;
    check(exp_w.size(), 32'h0);
    check(sensor_host_port_valid, 1'b0);
    check(demod_bit_out, last_w[3:0]);
    @(posedge clk);
    config_host_reset <= 1'b1;
    tick(1);
    config_host_reset <= 1'b0;
    mode(1'b1, 1'b0);
    trig(PLEN[0]);
    mode(1'b0, 1'b0);
    trig(32'h0);
    tick(20);
    check(exp_len.size(), 32'h0);
    close_out();
  end
  // watchdog
  initial begin
    tick(60000);
    mismatches++;
    close_out();
  end
endmodule : ssm_ctrl_bench
